/* src/csr_core_regs.sv */
`default_nettype none
`include "csr_defines.svh"
module csr_core_regs
   import csr_pkg::*;
(
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rstn,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [14:0]             paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic                         pready,
   output logic [31:0]                  prdata,
   output logic                         pslverr,
   // Instruction datapath
   input  wire csr_alu_req_t            alu_req,
   input  wire csr_cpu_evt_t            cpu_evt,
   input  wire logic [6:0]              direct_offset,
   output logic [7:0]                   alu_result,
   output logic [`CSR_PC_W-1:0]         pc,
   output logic [12:0]                  direct_addr,
   // Indirect window memory port
   output csr_mem_req_t                 mem_req,
   input  wire logic                    mem_ack,
   input  wire logic [7:0]              mem_rdata,
   // Interrupt control
   input  wire logic                    ext_irq_pin,
   input  wire logic                    periph_irq_event,
   output logic                         irq_request
);

   logic       rst_meta_ff;
   logic       rst_sync_ff;
   csr_state_t s_ff;
   csr_state_t nxt_s;

   // Release of the asynchronous reset is retimed to clk
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   function automatic logic [7:0] rd_value(input csr_state_t s,
                                           input logic [`CSR_IDX_W-1:0] idx);
      logic [7:0] v;
      v = 8'h00;
      if (idx == `CSR_IDX_STACK_POINTER) begin
         v = {3'h0, s.sp};
      end else if (idx == `CSR_IDX_TOS_LO) begin
         v = s.stack[s.sp][7:0];
      end else if (idx == `CSR_IDX_TOS_HI) begin
         v = s.stack[s.sp][15:8];
      end else begin
         unique case (idx[6:0] & `CSR_BANK_MASK)
            `CSR_IDX_PC_LOW:  v = s.pc[7:0];
            `CSR_IDX_STATUS:  v = {3'h0, s.status};
            `CSR_IDX_PTRA_LO: v = s.ptr_a[7:0];
            `CSR_IDX_PTRA_HI: v = s.ptr_a[15:8];
            `CSR_IDX_PTRB_LO: v = s.ptr_b[7:0];
            `CSR_IDX_PTRB_HI: v = s.ptr_b[15:8];
            `CSR_IDX_BANK:    v = {2'h0, s.bank};
            `CSR_IDX_WORKING_REGISTER:    v = s.working_register;
            `CSR_IDX_LATCH:   v = {1'h0, s.latch};
            `CSR_IDX_INTCTL:  v = s.intctl;
            `CSR_IDX_IRQFLG:  v = {6'h00, s.irq_flags};
            default:          v = 8'h00;
         endcase
      end
      return v;
   endfunction : rd_value

   function automatic logic is_mapped(input logic [`CSR_IDX_W-1:0] idx);
      logic m;
      m = (idx == `CSR_IDX_STACK_POINTER) || (idx == `CSR_IDX_TOS_LO) ||
          (idx == `CSR_IDX_TOS_HI) || (idx[6:0] <= `CSR_IDX_IRQFLG);
      return m;
   endfunction : is_mapped

   always_comb begin
      logic [`CSR_IDX_W-1:0] idx;
      logic [7:0]            wd;
      logic                  wr_en;
      logic                  win_a;
      logic                  win_b;
      logic                  ext_edge;
      logic [8:0]            sum9;
      logic [4:0]            sum5;
      logic [7:0]            opb_eff;
      logic                  cin;
      logic [7:0]            res;
      idx      = paddr[14:2];
      wd       = pwdata[7:0];
      wr_en    = pwrite && pstrb[0];
      win_a    = (idx[6:0] == `CSR_IDX_WIN_A) && (idx != `CSR_IDX_STACK_POINTER);
      win_b    = (idx[6:0] == `CSR_IDX_WIN_B);
      ext_edge = 1'b0;
      sum9     = 9'h000;
      sum5     = 5'h00;
      opb_eff  = 8'h00;
      cin      = 1'b0;
      res      = 8'h00;
      nxt_s    = s_ff;

      if (cpu_evt.pc_incr) begin
         nxt_s.pc = s_ff.pc + `CSR_PC_W'(1);
      end

      // Bus access: one wait state, longer when a window goes to memory
      unique case (s_ff.bus_st)
         CSR_BUS_IDLE: begin
            if (psel && penable) begin
               nxt_s.pslverr = !is_mapped(idx);
               nxt_s.prdata  = 8'h00;
               if (win_a || win_b) begin
                  nxt_s.mem.req   = 1'b1;
                  nxt_s.mem.wr    = wr_en;
                  nxt_s.mem.addr  = win_a ? s_ff.ptr_a : s_ff.ptr_b;
                  nxt_s.mem.wdata = wd;
                  nxt_s.bus_st    = CSR_BUS_MEM;
               end else begin
                  nxt_s.bus_st = CSR_BUS_DONE;
                  if (!pwrite) begin
                     nxt_s.prdata = rd_value(s_ff, idx);
                  end else if (wr_en) begin
                     if (idx == `CSR_IDX_STACK_POINTER) begin
                        nxt_s.sp = wd[`CSR_SP_W-1:0];
                     end else if (idx == `CSR_IDX_TOS_LO) begin
                        nxt_s.stack[s_ff.sp][7:0] = wd;
                     end else if (idx == `CSR_IDX_TOS_HI) begin
                        nxt_s.stack[s_ff.sp][15:8] = wd;
                     end else begin
                        unique case (idx[6:0])
                           `CSR_IDX_PC_LOW:  nxt_s.pc = {s_ff.latch, wd};
                           // Timeout and power-down bits ignore writes
                           `CSR_IDX_STATUS:  nxt_s.status = (s_ff.status & ~`CSR_ST_WR_MASK) |
                                                (wd[4:0] & `CSR_ST_WR_MASK);
                           `CSR_IDX_PTRA_LO: nxt_s.ptr_a[7:0]  = wd;
                           `CSR_IDX_PTRA_HI: nxt_s.ptr_a[15:8] = wd;
                           `CSR_IDX_PTRB_LO: nxt_s.ptr_b[7:0]  = wd;
                           `CSR_IDX_PTRB_HI: nxt_s.ptr_b[15:8] = wd;
                           `CSR_IDX_BANK:    nxt_s.bank  = wd[`CSR_BANK_W-1:0];
                           `CSR_IDX_WORKING_REGISTER:    nxt_s.working_register  = wd;
                           `CSR_IDX_LATCH:   nxt_s.latch = wd[`CSR_LATCH_W-1:0];
                           `CSR_IDX_INTCTL: begin
                              nxt_s.intctl[`CSR_IC_GIE]  = wd[`CSR_IC_GIE];
                              nxt_s.intctl[`CSR_IC_PERIPHERAL_IRQ_ENABLE] = wd[`CSR_IC_PERIPHERAL_IRQ_ENABLE];
                              nxt_s.intctl[`CSR_IC_EDGE] = wd[`CSR_IC_EDGE];
                           end
                           `CSR_IDX_IRQFLG:  nxt_s.irq_flags = s_ff.irq_flags & ~wd[1:0];
                           default: ;
                        endcase
                     end
                  end
               end
            end
         end
         CSR_BUS_MEM: begin
            if (mem_ack) begin
               nxt_s.mem.req = 1'b0;
               nxt_s.prdata  = s_ff.mem.wr ? 8'h00 : mem_rdata;
               nxt_s.bus_st  = CSR_BUS_DONE;
            end
         end
         CSR_BUS_DONE: begin
            nxt_s.bus_st = CSR_BUS_IDLE;
         end
      endcase

      // Datapath flag updates take priority over a same-cycle bus write
      opb_eff = (alu_req.op == CSR_OP_SUB) ? ~alu_req.opb : alu_req.opb;
      cin     = (alu_req.op == CSR_OP_SUB);
      sum9    = {1'b0, alu_req.opa} + {1'b0, opb_eff} + {8'h00, cin};
      sum5    = {1'b0, alu_req.opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, cin};
      unique case (alu_req.op)
         CSR_OP_ADD, CSR_OP_SUB: begin
            res = sum9[7:0];
            nxt_s.status[`CSR_ST_DC] = sum5[4];
            nxt_s.status[`CSR_ST_C]  = sum9[8];
            nxt_s.status[`CSR_ST_Z]  = (res == 8'h00);
         end
         CSR_OP_AND, CSR_OP_IOR, CSR_OP_XOR: begin
            res = (alu_req.op == CSR_OP_AND) ? (alu_req.opa & alu_req.opb) :
                  (alu_req.op == CSR_OP_IOR) ? (alu_req.opa | alu_req.opb) :
                                               (alu_req.opa ^ alu_req.opb);
            nxt_s.status[`CSR_ST_Z] = (res == 8'h00);
         end
         CSR_OP_RLC: begin
            res = {alu_req.opa[6:0], s_ff.status[`CSR_ST_C]};
            nxt_s.status[`CSR_ST_C] = alu_req.opa[7];
         end
         CSR_OP_RRC: begin
            res = {s_ff.status[`CSR_ST_C], alu_req.opa[7:1]};
            nxt_s.status[`CSR_ST_C] = alu_req.opa[0];
         end
         CSR_OP_NONE: begin
            res = s_ff.alu_res;
         end
      endcase
      nxt_s.alu_res = res;

      // Timeout outranks clear/sleep; sleep outranks clear for power-down
      if (cpu_evt.wdt_clear || cpu_evt.sleep) begin
         nxt_s.status[`CSR_ST_TO] = 1'b1;
      end
      if (cpu_evt.wdt_timeout) begin
         nxt_s.status[`CSR_ST_TO] = 1'b0;
      end
      if (cpu_evt.wdt_clear) begin
         nxt_s.status[`CSR_ST_PD] = 1'b1;
      end
      if (cpu_evt.sleep) begin
         nxt_s.status[`CSR_ST_PD] = 1'b0;
      end

      // Flags latch whatever the enables say, so polling works
      nxt_s.ext_prev = ext_irq_pin;
      ext_edge = s_ff.intctl[`CSR_IC_EDGE] ? (ext_irq_pin && !s_ff.ext_prev)
                                           : (!ext_irq_pin && s_ff.ext_prev);
      if (ext_edge) begin
         nxt_s.irq_flags[`CSR_FLG_EXT] = 1'b1;
      end
      if (periph_irq_event) begin
         nxt_s.irq_flags[`CSR_FLG_PER] = 1'b1;
      end

      // Warm reset keeps status and stack contents
      if (cpu_evt.warm_reset) begin
         nxt_s.pc        = '0;
         nxt_s.latch     = '0;
         nxt_s.ptr_a     = 16'h0000;
         nxt_s.ptr_b     = 16'h0000;
         nxt_s.bank      = '0;
         nxt_s.working_register      = 8'h00;
         nxt_s.intctl    = 8'h00;
         nxt_s.intctl[`CSR_IC_EDGE] = `CSR_EDGE_RESET;
         nxt_s.irq_flags = 2'h0;
         nxt_s.sp        = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         s_ff        <= '0;
         s_ff.bus_st <= CSR_BUS_IDLE;
         s_ff.status <= `CSR_ST_RESET;
         s_ff.intctl <= {7'h00, `CSR_EDGE_RESET};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign pready      = (s_ff.bus_st == CSR_BUS_DONE);
   assign prdata      = {24'h000000, s_ff.prdata};
   assign pslverr     = pready && s_ff.pslverr;
   assign alu_result  = s_ff.alu_res;
   assign pc          = s_ff.pc;
   assign direct_addr = {s_ff.bank, direct_offset};
   assign mem_req     = s_ff.mem;
   // Software must clear stale flags before enabling
   assign irq_request = s_ff.intctl[`CSR_IC_GIE] &&
                        (s_ff.irq_flags[`CSR_FLG_EXT] ||
                         (s_ff.intctl[`CSR_IC_PERIPHERAL_IRQ_ENABLE] && s_ff.irq_flags[`CSR_FLG_PER]));

endmodule : csr_core_regs
`default_nettype wire

/* src/csr_defines.svh */
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

`define CSR_IDX_W        13
`define CSR_BANK_MASK    7'h7F
`define CSR_IDX_WIN_A    7'h00
`define CSR_IDX_WIN_B    7'h01
`define CSR_IDX_PC_LOW   7'h02
`define CSR_IDX_STATUS   7'h03
`define CSR_IDX_PTRA_LO  7'h04
`define CSR_IDX_PTRA_HI  7'h05
`define CSR_IDX_PTRB_LO  7'h06
`define CSR_IDX_PTRB_HI  7'h07
`define CSR_IDX_BANK     7'h08
`define CSR_IDX_WORKING_REGISTER     7'h09
`define CSR_IDX_LATCH    7'h0A
`define CSR_IDX_INTCTL   7'h0B
`define CSR_IDX_IRQFLG   7'h0C
`define CSR_IDX_STACK_POINTER   13'h1FED
`define CSR_IDX_TOS_LO   13'h1FEE
`define CSR_IDX_TOS_HI   13'h1FEF

`define CSR_ST_TO        4
`define CSR_ST_PD        3
`define CSR_ST_Z         2
`define CSR_ST_DC        1
`define CSR_ST_C         0
`define CSR_ST_RESET     5'h18
`define CSR_ST_WR_MASK   5'h07

`define CSR_IC_GIE       7
`define CSR_IC_PERIPHERAL_IRQ_ENABLE      6
`define CSR_IC_EDGE      0
`define CSR_EDGE_RESET   1'h1
`define CSR_FLG_EXT      0
`define CSR_FLG_PER      1

`define CSR_STACK_DEPTH  32
`define CSR_SP_W         5
`define CSR_PC_W         15
`define CSR_LATCH_W      7
`define CSR_BANK_W       6

`endif

/* src/csr_pkg.sv */
`default_nettype none
`include "csr_defines.svh"
package csr_pkg;

   typedef enum logic [2:0] {
      CSR_OP_NONE, CSR_OP_ADD, CSR_OP_SUB, CSR_OP_AND,
      CSR_OP_IOR, CSR_OP_XOR, CSR_OP_RLC, CSR_OP_RRC
   } csr_alu_op_t;

   typedef struct packed {
      csr_alu_op_t op;
      logic [7:0]  opa;
      logic [7:0]  opb;
   } csr_alu_req_t;

   typedef struct packed {
      logic wdt_clear;
      logic sleep;
      logic wdt_timeout;
      logic warm_reset;
      logic pc_incr;
   } csr_cpu_evt_t;

   typedef struct packed {
      logic        req;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } csr_mem_req_t;

   typedef enum logic [1:0] {CSR_BUS_IDLE, CSR_BUS_MEM, CSR_BUS_DONE} csr_bus_st_t;

   typedef struct packed {
      csr_bus_st_t                                bus_st;
      logic [7:0]                                 prdata;
      logic                                       pslverr;
      logic [`CSR_PC_W-1:0]                       pc;
      logic [`CSR_LATCH_W-1:0]                    latch;
      logic [4:0]                                 status;
      logic [15:0]                                ptr_a;
      logic [15:0]                                ptr_b;
      logic [`CSR_BANK_W-1:0]                     bank;
      logic [7:0]                                 working_register;
      logic [7:0]                                 intctl;
      logic [1:0]                                 irq_flags;
      logic                                       ext_prev;
      logic [`CSR_SP_W-1:0]                       sp;
      logic [`CSR_STACK_DEPTH-1:0][15:0]          stack;
      logic [7:0]                                 alu_res;
      csr_mem_req_t                               mem;
   } csr_state_t;

endpackage : csr_pkg
`default_nettype wire

/* test/csr_core_regs_monitor.sv */
`default_nettype none
module csr_core_regs_monitor
   import csr_pkg::*;
(
   // Clock and reset
   input wire logic         clk,
   input wire logic         rstn,
   // Register bus answer
   input wire logic         pready,
   input wire logic [31:0]  prdata,
   input wire logic         pslverr,
   // Datapath
   input wire csr_alu_req_t alu_req,
   input wire logic [7:0]   alu_result,
   input wire logic [6:0]   direct_offset,
   input wire logic [12:0]  direct_addr,
   // Window memory port
   input wire csr_mem_req_t mem_req,
   input wire logic         mem_ack
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   add_result_a: assert property (alu_req.op == CSR_OP_ADD |=>
      alu_result == 8'($past(alu_req.opa) + $past(alu_req.opb))) else $error("add result wrong");
   sub_result_a: assert property (alu_req.op == CSR_OP_SUB |=>
      alu_result == 8'($past(alu_req.opa) - $past(alu_req.opb))) else $error("sub result wrong");
   rot_left_a: assert property (alu_req.op == CSR_OP_RLC |=>
      alu_result[7:1] == 7'($past(alu_req.opa))) else $error("left rotate wrong");
   rot_right_a: assert property (alu_req.op == CSR_OP_RRC |=>
      alu_result[6:0] == 7'($past(alu_req.opa) >> 1)) else $error("right rotate wrong");
   alu_hold_a: assert property (alu_req.op == CSR_OP_NONE |=>
      $stable(alu_result)) else $error("result moved without op");
   bank_offset_a: assert property (direct_addr[6:0] == direct_offset)
      else $error("direct address low bits wrong");
   mem_hold_a: assert property (mem_req.req && !mem_ack |=>
      mem_req.req && $stable(mem_req.addr)) else $error("window request dropped");
   win_answer_a: assert property (mem_ack |=> pready)
      else $error("window answer late");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_gated_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without answer");

   cover property (mem_ack);
   cover property (alu_req.op == CSR_OP_SUB);
   cover property (pslverr);
endmodule : csr_core_regs_monitor

bind csr_core_regs csr_core_regs_monitor csr_core_regs_monitor_i (.clk(clk), .rstn(rstn),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .alu_req(alu_req),
   .alu_result(alu_result), .direct_offset(direct_offset), .direct_addr(direct_addr),
   .mem_req(mem_req), .mem_ack(mem_ack));
`default_nettype wire

/* test/csr_core_regs_tb_top.sv */
`default_nettype none
`include "csr_defines.svh"
module csr_core_regs_tb_top
   import csr_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   logic         clk, rstn, psel, penable, pwrite, pready, pslverr, err;
   logic         mem_ack, ext_irq_pin, periph_irq_event, irq_request;
   logic [14:0]  paddr, pc;
   logic [31:0]  pwdata, prdata, rd;
   logic [3:0]   pstrb;
   logic [6:0]   direct_offset;
   logic [7:0]   alu_result, mem_rdata;
   logic [12:0]  direct_addr;
   logic [1:0]   mdly;
   csr_alu_req_t alu_req;
   csr_cpu_evt_t cpu_evt;
   csr_mem_req_t mem_req, cap;
   int           n_fail, n_tests;

   csr_core_regs csr_core_regs_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .alu_req(alu_req), .cpu_evt(cpu_evt),
      .direct_offset(direct_offset), .alu_result(alu_result), .pc(pc),
      .direct_addr(direct_addr), .mem_req(mem_req), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .ext_irq_pin(ext_irq_pin),
      .periph_irq_event(periph_irq_event), .irq_request(irq_request));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Slow memory: answers two cycles late, data bus scrambles when idle
   always @(posedge clk) begin
      mem_ack <= 1'b0;
      if (!rstn) begin
         mdly <= 2'h0;
         mem_rdata <= 8'h00;
      end else if (mem_req.req && !mem_ack && mdly == 2'h2) begin
         mem_ack <= 1'b1;
         mdly <= 2'h0;
         mem_rdata <= mem_req.addr[7:0] ^ 8'h5A;
         cap <= mem_req;
      end else begin
         mdly <= (mem_req.req && !mem_ack) ? mdly + 2'h1 : 2'h0;
         mem_rdata <= ~mem_rdata;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic w, input logic [12:0] idx, input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [12:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task rdc(input logic [12:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk(rd, {24'h000000, e});
   endtask : rdc

   task evt(input logic [4:0] e);
      cpu_evt <= csr_cpu_evt_t'(e);
      @(posedge clk);
      cpu_evt <= '0;
   endtask : evt

   task t_reset;
      rdc(`CSR_IDX_STATUS, 8'h18);
      rdc(`CSR_IDX_INTCTL, 8'h01);
      rdc(`CSR_IDX_PTRA_HI, 8'h00);
      rdc(`CSR_IDX_PTRB_LO, 8'h00);
      rdc(`CSR_IDX_STACK_POINTER, 8'h00);
      rdc(`CSR_IDX_TOS_HI, 8'h00);
   endtask : t_reset

   task t_regs;
      wr(`CSR_IDX_PTRA_LO, 8'h34);
      wr(`CSR_IDX_PTRA_HI, 8'h12);
      wr(`CSR_IDX_PTRB_LO, 8'h45);
      wr(`CSR_IDX_PTRB_HI, 8'h23);
      rdc(`CSR_IDX_PTRA_LO, 8'h34);
      rdc(`CSR_IDX_PTRA_HI, 8'h12);
      rdc(`CSR_IDX_PTRB_LO, 8'h45);
      rdc(`CSR_IDX_PTRB_HI, 8'h23);
      wr(`CSR_IDX_BANK, 8'hEA);
      rdc(`CSR_IDX_BANK, 8'h2A);
      direct_offset <= 7'h55;
      @(posedge clk);
      chk(direct_addr, {6'h2A, 7'h55});
      wr(`CSR_IDX_WORKING_REGISTER, 8'hA5);
      wr(`CSR_IDX_INTCTL, 8'hFF);
      rdc(`CSR_IDX_INTCTL, 8'hC1);
      wr(`CSR_IDX_INTCTL, 8'h01);
      wr(`CSR_IDX_STATUS, 8'h07);
      rdc(`CSR_IDX_STATUS, 8'h1F);
      apb(1'b0, 13'h000D, 8'h00);
      chk(err, 1'b1);
      chk(rd, 32'h00000000);
   endtask : t_regs

   task t_pc;
      wr(13'h1F8A, 8'hFF);
      chk(pc, 15'h0);
      rdc(`CSR_IDX_LATCH, 8'h7F);
      wr(`CSR_IDX_LATCH, 8'h12);
      wr(`CSR_IDX_PC_LOW, 8'h34);
      chk(pc, 15'h1234);
      evt(5'h01);
      @(posedge clk);
      chk(pc, 15'h1235);
      rdc(13'h1F82, 8'h35);
   endtask : t_pc

   task t_alu;
      csr_alu_op_t op_t [9];
      logic [7:0]  a_t [9];
      logic [7:0]  b_t [9];
      logic [7:0]  r_t [9];
      logic [2:0]  f_t [9];
      op_t = '{CSR_OP_ADD, CSR_OP_ADD, CSR_OP_SUB, CSR_OP_SUB, CSR_OP_RLC,
               CSR_OP_RRC, CSR_OP_AND, CSR_OP_XOR, CSR_OP_IOR};
      a_t = '{8'h0F, 8'hFF, 8'h05, 8'h00, 8'h80, 8'h01, 8'hF0, 8'h3C, 8'h00};
      b_t = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h00, 8'h00, 8'h0F, 8'h0C, 8'h00};
      r_t = '{8'h10, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h80, 8'h00, 8'h30, 8'h00};
      f_t = '{3'h2, 3'h7, 3'h7, 3'h0, 3'h1, 3'h1, 3'h5, 3'h1, 3'h5};
      for (int i = 0; i < 9; i++) begin
         alu_req <= '{op_t[i], a_t[i], b_t[i]};
         @(posedge clk);
         alu_req.op <= CSR_OP_NONE;
         rdc(`CSR_IDX_STATUS, {5'h03, f_t[i]});
         chk(alu_result, r_t[i]);
      end
   endtask : t_alu

   task t_flags;
      evt(5'h04);
      rdc(`CSR_IDX_STATUS, 8'h0D);
      evt(5'h08);
      rdc(`CSR_IDX_STATUS, 8'h15);
      evt(5'h10);
      rdc(`CSR_IDX_STATUS, 8'h1D);
   endtask : t_flags

   task t_win;
      apb(1'b0, `CSR_IDX_WIN_A, 8'h00);
      chk(rd, 8'h6E);
      chk({cap.wr, cap.addr}, 17'h01234);
      apb(1'b1, `CSR_IDX_WIN_B, 8'h77);
      chk({cap.wr, cap.addr, cap.wdata}, 25'h1234577);
   endtask : t_win

   task t_stack;
      wr(`CSR_IDX_STACK_POINTER, 8'h05);
      wr(`CSR_IDX_TOS_LO, 8'hEF);
      wr(`CSR_IDX_TOS_HI, 8'hBE);
      wr(`CSR_IDX_STACK_POINTER, 8'h06);
      wr(`CSR_IDX_TOS_LO, 8'h11);
      rdc(`CSR_IDX_TOS_LO, 8'h11);
      wr(`CSR_IDX_STACK_POINTER, 8'h05);
      rdc(`CSR_IDX_TOS_LO, 8'hEF);
      rdc(`CSR_IDX_TOS_HI, 8'hBE);
      wr(`CSR_IDX_STACK_POINTER, 8'hFF);
      rdc(`CSR_IDX_STACK_POINTER, 8'h1F);
   endtask : t_stack

   task t_irq;
      ext_irq_pin <= 1'b1;
      rdc(`CSR_IDX_IRQFLG, 8'h01);
      chk(irq_request, 1'b0);
      // Stale flags go before any enable is set
      wr(`CSR_IDX_IRQFLG, 8'h01);
      wr(`CSR_IDX_INTCTL, 8'h81);
      chk(irq_request, 1'b0);
      ext_irq_pin <= 1'b0;
      @(posedge clk);
      ext_irq_pin <= 1'b1;
      rdc(`CSR_IDX_IRQFLG, 8'h01);
      chk(irq_request, 1'b1);
      wr(`CSR_IDX_IRQFLG, 8'h01);
      periph_irq_event <= 1'b1;
      @(posedge clk);
      periph_irq_event <= 1'b0;
      rdc(`CSR_IDX_IRQFLG, 8'h02);
      chk(irq_request, 1'b0);
      wr(`CSR_IDX_IRQFLG, 8'h02);
      wr(`CSR_IDX_INTCTL, 8'hC1);
      chk(irq_request, 1'b0);
      periph_irq_event <= 1'b1;
      @(posedge clk);
      periph_irq_event <= 1'b0;
      rdc(`CSR_IDX_IRQFLG, 8'h02);
      chk(irq_request, 1'b1);
      wr(`CSR_IDX_INTCTL, 8'h00);
      wr(`CSR_IDX_IRQFLG, 8'h03);
      ext_irq_pin <= 1'b0;
      rdc(`CSR_IDX_IRQFLG, 8'h01);
   endtask : t_irq

   task t_warm;
      evt(5'h02);
      rdc(`CSR_IDX_STATUS, 8'h1D);
      rdc(`CSR_IDX_WORKING_REGISTER, 8'h00);
      rdc(`CSR_IDX_INTCTL, 8'h01);
   endtask : t_warm

   task finish_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      finish_test;
   end

   initial begin
      {rstn, psel, penable, pwrite, ext_irq_pin, periph_irq_event} = '0;
      {paddr, pwdata, direct_offset} = '0;
      pstrb = 4'hF;
      alu_req = '0;
      cpu_evt = '0;
      n_fail = 0;
      n_tests = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset;
      t_regs;
      t_pc;
      t_alu;
      t_flags;
      t_win;
      t_stack;
      t_irq;
      t_warm;
      finish_test;
   end
endmodule : csr_core_regs_tb_top
`default_nettype wire
